// ### common/sfb_defines.vh
// constants for the framed serial unit with transmit buffer
`ifndef SFB_DEFINES_VH
`define SFB_DEFINES_VH
// ---------------------------------------------------------------
// widths and timing
// ---------------------------------------------------------------
`define SFB_WORD_W 16
`define SFB_CLK_MHZ 40
`define SFB_SCK_PERIOD_NS 400
// clock enable divider: half a serial period in system cycles
`define SFB_HALF_CYC ((`SFB_SCK_PERIOD_NS * `SFB_CLK_MHZ) / 2000)
`define SFB_DIV_W 8
`define SFB_CNT_W 5
// reset values
`define SFB_WORD_RST 16'h0000
`endif

// ### rtl/sfb_sync2.v
// two-flop synchroniser for a single asynchronous level
`timescale 1ns/1ps
`default_nettype none
module sfb_sync2
(
  input wire i_clk, // system clock
  input wire i_arst_n, // asynchronous reset, active low
  input wire i_d, // asynchronous level
  output wire o_q // synchronised level
);
  // ---------------------------------------------------------------
  // flop chain
  // ---------------------------------------------------------------
  reg meta_r; // first stage, read by second only
  reg sync_r; // second stage
  // capture chain
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= i_d;
      sync_r <= meta_r;
    end
  end
  assign o_q = sync_r;
endmodule // sfb_sync2
`default_nettype wire

// ### rtl/sfb_spi.v
// framed serial unit: master/slave shifter with transmit buffer
// Behaviour
// - framed master mode keeps serial clock running continuously
// - frame sync pulse on slave select starts frame
// - late sampling only with or after master enable
// - transfer start moves buffer word into shifter
// - buffer reported empty once transmission starts
`timescale 1ns/1ps
`default_nettype none
`include "sfb_defines.vh"
module sfb_spi
#(
  parameter WORD_W = `SFB_WORD_W, // word width
  parameter HALF_CYC = `SFB_HALF_CYC // system cycles per half period
)
(
  input wire i_clk, // system clock, 40 MHz
  input wire i_arst_n, // asynchronous reset, active low
  input wire i_cfg_we, // configuration write strobe
  input wire i_master_role_enable, // write data: master role
  input wire i_late_input_sampling, // write data: late sampling
  input wire i_framed_operation_enable, // write data: framed mode
  input wire i_slave_select_control_enable, // write data: ss gating
  input wire i_unit_enable, // write data: unit on
  input wire i_buf_we, // transmit buffer write strobe
  input wire [WORD_W-1:0] i_buf_wdata, // transmit word
  input wire i_serial_clock_pin, // serial clock from pin
  input wire i_slave_select_pin, // slave select / frame sync pin
  input wire i_sdi, // serial data in
  output reg o_serial_clock_pin, // serial clock drive
  output reg o_serial_clock_oe, // serial clock output enable
  output reg o_slave_select_pin, // frame sync drive
  output reg o_slave_select_oe, // frame sync output enable
  output reg o_sdo, // serial data out
  output reg o_master_role, // stored master role
  output reg o_late_sampling, // stored late sampling
  output reg o_framed, // stored framed mode
  output reg o_ss_ctrl, // stored slave-select control
  output reg o_cfg_invalid, // invalid framing/ss combination
  output wire o_tx_buf_empty, // transmit buffer free
  output reg o_rx_valid, // one-cycle pulse, word received
  output reg [WORD_W-1:0] o_rx_data // last received word
);
  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  reg enable_r; // unit on
  // configuration write; late sampling gated by master role
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      enable_r <= 1'b0;
      o_master_role <= 1'b0;
      o_late_sampling <= 1'b0;
      o_framed <= 1'b0;
      o_ss_ctrl <= 1'b0;
      o_cfg_invalid <= 1'b0;
    end
    else if (i_cfg_we)
    begin
      enable_r <= i_unit_enable;
      o_master_role <= i_master_role_enable;
      // only same write or later write as master enable
      o_late_sampling <= i_late_input_sampling & i_master_role_enable;
      o_framed <= i_framed_operation_enable;
      o_ss_ctrl <= i_slave_select_control_enable;
      // flag the combination software must not program
      o_cfg_invalid <= i_framed_operation_enable &
                       i_slave_select_control_enable;
    end
  end
  // framed wins; select gating dropped when framed
  wire ss_gate = o_ss_ctrl & ~o_framed;
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  wire sck_s; // synchronised serial clock
  wire ss_s; // synchronised slave select
  wire sdi_s; // synchronised data in
  sfb_sync2 u_sync_sck (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_d(i_serial_clock_pin), .o_q(sck_s));
  sfb_sync2 u_sync_ss (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_d(i_slave_select_pin), .o_q(ss_s));
  sfb_sync2 u_sync_sdi (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_d(i_sdi), .o_q(sdi_s));
  reg sck_d_r; // delayed synchronised clock
  reg ss_d_r; // delayed synchronised select
  // edge history
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sck_d_r <= 1'b0;
      ss_d_r <= 1'b1;
    end
    else
    begin
      sck_d_r <= sck_s;
      ss_d_r <= ss_s;
    end
  end
  wire s_rise = sck_s & ~sck_d_r; // slave sample edge
  wire s_fall = ~sck_s & sck_d_r; // slave shift edge
  wire s_sync = ss_s & ~ss_d_r; // frame sync pulse seen
  wire s_ssel = ~ss_s; // active-low select asserted
  // ---------------------------------------------------------------
  // clock divider for master mode
  // ---------------------------------------------------------------
  reg [`SFB_DIV_W-1:0] div_r; // half period counter
  wire half_tick = (div_r == HALF_CYC[`SFB_DIV_W-1:0] - 8'h01);
  // one-cycle enable every half serial period
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      div_r <= 8'h00;
    else if (half_tick || !enable_r || !o_master_role)
      div_r <= 8'h00;
    else
      div_r <= div_r + 8'h01;
  end
  // ---------------------------------------------------------------
  // transmit buffer and shifter
  // ---------------------------------------------------------------
  reg [WORD_W-1:0] buf_r; // transmit buffer
  reg buf_full_r; // buffer holds unsent word
  reg [WORD_W-1:0] shift_r; // shift register
  reg [`SFB_CNT_W-1:0] bit_r; // bits left in word
  reg busy_r; // word in flight
  reg sample_r; // bit captured at leading edge
  reg m_phase_r; // master clock level
  wire m_run = enable_r & o_master_role & (busy_r | o_framed | buf_full_r);
  // transfer start condition per role
  wire start = !busy_r && enable_r && (o_master_role ?
    (half_tick && m_phase_r && (buf_full_r || o_framed)) :
    (o_framed ? s_sync : (s_ssel || !ss_gate)) && s_fall);
  wire lead = o_master_role ? (half_tick & ~m_phase_r) : s_rise;
  wire trail = o_master_role ? (half_tick & m_phase_r) : s_fall;
  wire last_bit = (bit_r == 5'd1);
  wire take = lead & busy_r; // sample edge during a word
  wire shift = trail & busy_r & ~last_bit; // shift out next bit
  // master ends on its own trailing edge; a slave ends on the last
  // sample edge, since the far master need not give a 17th fall
  wire done = busy_r & last_bit & (o_master_role ? trail : lead);
  // final bit: slave and late sampling take the live synced level
  wire last_in = (o_late_sampling | ~o_master_role) ? sdi_s : sample_r;
  assign o_tx_buf_empty = ~buf_full_r;
  // buffer, shifter and master clock
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      buf_r <= `SFB_WORD_RST;
      buf_full_r <= 1'b0;
      shift_r <= `SFB_WORD_RST;
      bit_r <= 5'd0;
      busy_r <= 1'b0;
      sample_r <= 1'b0;
      m_phase_r <= 1'b1;
      o_rx_valid <= 1'b0;
      o_rx_data <= `SFB_WORD_RST;
    end
    else
    begin
      o_rx_valid <= 1'b0;
      // master clock toggles; framed keeps it running
      if (m_run && half_tick)
        m_phase_r <= ~m_phase_r;
      else if (!m_run)
        m_phase_r <= 1'b1;
      // late sampling takes bit at trailing edge instead
      if (take && !o_late_sampling)
        sample_r <= sdi_s;
      if (start)
      begin
        // buffer word moves to shifter, buffer freed
        shift_r <= buf_full_r ? buf_r : `SFB_WORD_RST;
        buf_full_r <= i_buf_we; // write on start cycle stays queued
        bit_r <= WORD_W[`SFB_CNT_W-1:0];
        busy_r <= 1'b1;
      end
      else if (i_buf_we)
        buf_full_r <= 1'b1;
      if (i_buf_we)
        buf_r <= i_buf_wdata;
      if (shift)
      begin
        shift_r <= {shift_r[WORD_W-2:0],
                    o_late_sampling ? sdi_s : sample_r};
        bit_r <= bit_r - 5'd1;
      end
      if (done)
      begin
        busy_r <= 1'b0;
        bit_r <= 5'd0;
        o_rx_valid <= 1'b1;
        o_rx_data <= {shift_r[WORD_W-2:0], last_in};
      end
      if (!enable_r)
        busy_r <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  // clock, frame sync and data outputs
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_serial_clock_pin <= 1'b1;
      o_serial_clock_oe <= 1'b0;
      o_slave_select_pin <= 1'b1;
      o_slave_select_oe <= 1'b0;
      o_sdo <= 1'b0;
    end
    else
    begin
      o_serial_clock_pin <= m_phase_r;
      o_serial_clock_oe <= enable_r & o_master_role;
      o_slave_select_oe <= enable_r & o_master_role &
                           (o_framed | ss_gate);
      // sync pulse for one clock period at frame start
      if (o_framed)
        o_slave_select_pin <= ~(start | (busy_r & ~trail &
                              (bit_r == WORD_W[`SFB_CNT_W-1:0])));
      else
        o_slave_select_pin <= ~(busy_r | start);
      // next bit leaves with the shift, a cycle ahead of the far edge
      o_sdo <= start ? buf_r[WORD_W-1] :
               (shift ? shift_r[WORD_W-2] : shift_r[WORD_W-1]);
    end
  end
endmodule // sfb_spi
`default_nettype wire

// ### tb/sfb_chk.sv
// assertions for the framed serial unit
`timescale 1ns/1ps
`default_nettype none
module sfb_chk
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_cfg_we,
  input wire logic i_master_role_enable,
  input wire logic i_late_input_sampling,
  input wire logic i_framed_operation_enable,
  input wire logic i_slave_select_control_enable,
  input wire logic i_unit_enable,
  input wire logic i_buf_we,
  input wire logic o_serial_clock_pin,
  input wire logic o_slave_select_pin,
  input wire logic o_master_role,
  input wire logic o_late_sampling,
  input wire logic o_framed,
  input wire logic o_cfg_invalid,
  input wire logic o_tx_buf_empty
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic on_r; // unit enable as last written
  always_ff @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n)
      on_r <= 1'b0;
    else if (i_cfg_we)
      on_r <= i_unit_enable;
  logic [4:0] stall_r; // cycles the serial clock stood still
  logic [5:0] low_n_r; // cycles the select line stood low
  always_ff @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n)
      stall_r <= 5'd0;
    else if (on_r && o_framed && o_master_role &&
             $stable(o_serial_clock_pin) && stall_r != 5'd31)
      stall_r <= stall_r + 5'd1;
    else
      stall_r <= 5'd0;
  always_ff @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n)
      low_n_r <= 6'd0;
    else if (o_slave_select_pin)
      low_n_r <= 6'd0;
    else if (low_n_r != 6'd63)
      low_n_r <= low_n_r + 6'd1;
  // sync pulse: first half of the low bit time
  sequence s_pulse;
    (!o_slave_select_pin)[*8];
  endsequence
  property p_late;
    i_cfg_we |=> o_late_sampling ==
      ($past(i_late_input_sampling) & $past(i_master_role_enable));
  endproperty
  a_late: assert property (p_late) else $error("late sampling");
  property p_inv;
    i_cfg_we |=> o_framed == $past(i_framed_operation_enable) &&
      o_cfg_invalid == ($past(i_framed_operation_enable) &
      $past(i_slave_select_control_enable));
  endproperty
  a_inv: assert property (p_inv) else $error("invalid combination");
  property p_full;
    i_buf_we && o_tx_buf_empty |=> !o_tx_buf_empty;
  endproperty
  a_full: assert property (p_full) else $error("buffer not full");
  property p_start;
    o_master_role && !o_framed && $fell(o_slave_select_pin) |-> ##[0:1]
      o_tx_buf_empty;
  endproperty
  a_start: assert property (p_start) else $error("buffer not freed");
  property p_sck;
    stall_r <= 5'd12;
  endproperty
  a_sck: assert property (p_sck) else $error("serial clock stopped");
  property p_sync;
    on_r && o_framed && o_master_role && $fell(o_slave_select_pin) |->
      s_pulse ##9 (o_slave_select_pin && low_n_r == 6'd16);
  endproperty
  a_sync: assert property (p_sync) else $error("sync pulse width");
endmodule // sfb_chk
bind sfb_spi sfb_chk i_sfb_chk (.i_clk, .i_arst_n, .i_cfg_we,
  .i_master_role_enable, .i_late_input_sampling, .i_framed_operation_enable,
  .i_slave_select_control_enable, .i_unit_enable, .i_buf_we,
  .o_serial_clock_pin, .o_slave_select_pin, .o_master_role, .o_late_sampling,
  .o_framed, .o_cfg_invalid, .o_tx_buf_empty);
`default_nettype wire

// ### tb/sfb_partner.sv
// far-side device model on the serial link
`timescale 1ns/1ps
`default_nettype none
module sfb_partner
(
  input wire logic i_sck, // serial clock wire
  input wire logic i_ss_n, // select or frame sync wire
  input wire logic i_sdo, // data from the unit
  input wire logic [15:0] i_reply, // word sent back
  output logic o_sdi, // data to the unit
  output logic [15:0] o_word // word captured, msb first
);
  int cnt = 16; // bits taken in the current word
  initial o_sdi = 1'b0;
  initial o_word = 16'h0000;
  // select fall opens a word; reply is ready ahead of the cycle
  always @(negedge i_ss_n)
  begin
    cnt = 0;
    o_sdi = i_reply[15];
  end
  // sample on rise
  always @(posedge i_sck)
    if (cnt < 16)
    begin
      o_word = {o_word[14:0], i_sdo};
      cnt++;
    end
  // next bit on fall; an idle line keeps changing
  always @(negedge i_sck)
    o_sdi = (cnt == 0) ? o_sdi : (cnt < 16) ? i_reply[15 - cnt] : ~o_sdi;
endmodule // sfb_partner
`default_nettype wire

// ### tb/tb_sfb_spi.sv
// bench for the framed serial unit
`timescale 1ns/1ps
`default_nettype none
module tb_sfb_spi;
  logic clk, arst_n, cfg_we, m, l, f, s, u, buf_we, tb_sck, tb_ss, sdi;
  logic [15:0] wdata, word, rxd;
  logic sck_o, sck_oe, ss_o, ss_oe, sdo, mr, ls, fr, sc, inv, emp, rxv;
  wire sck_w = sck_oe ? sck_o : tb_sck; // pin level from both drivers
  wire ss_w = ss_oe ? ss_o : tb_ss;
  int fail_count, checks_done, cyc, i;
  sfb_spi i_sfb_spi (.i_clk(clk), .i_arst_n(arst_n), .i_cfg_we(cfg_we),
    .i_master_role_enable(m), .i_late_input_sampling(l),
    .i_framed_operation_enable(f), .i_slave_select_control_enable(s),
    .i_unit_enable(u), .i_buf_we(buf_we), .i_buf_wdata(wdata),
    .i_serial_clock_pin(sck_w), .i_slave_select_pin(ss_w), .i_sdi(sdi),
    .o_serial_clock_pin(sck_o), .o_serial_clock_oe(sck_oe),
    .o_slave_select_pin(ss_o), .o_slave_select_oe(ss_oe), .o_sdo(sdo),
    .o_master_role(mr), .o_late_sampling(ls), .o_framed(fr), .o_ss_ctrl(sc),
    .o_cfg_invalid(inv), .o_tx_buf_empty(emp), .o_rx_valid(rxv),
    .o_rx_data(rxd));
  sfb_partner i_sfb_partner (.i_sck(sck_w), .i_ss_n(ss_w), .i_sdo(sdo),
    .i_reply(16'h3c5a), .o_sdi(sdi), .o_word(word));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one config write of {master, late, framed, select, unit}
  task automatic cfg(input logic [4:0] v);
    @(posedge clk);
    {m, l, f, s, u} <= v;
    cfg_we <= 1'b1;
    @(posedge clk);
    cfg_we <= 1'b0;
    #1;
  endtask
  task automatic put(input logic [15:0] v);
    @(posedge clk);
    wdata <= v;
    buf_we <= 1'b1;
    @(posedge clk);
    buf_we <= 1'b0;
    #1;
  endtask
  task automatic wait_rx;
    for (i = 0; i < 400 && rxv !== 1'b1; i++)
      @(posedge clk) #1;
    chk({15'h0, rxv}, 16'h0001);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      summarize;
    end
  end
  initial
  begin
    {cfg_we, m, l, f, s, u, buf_we} = 7'h00;
    {tb_sck, tb_ss, wdata, arst_n} = {2'b11, 16'h0000, 1'b0};
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk({13'h0, emp, ss_o, sck_o}, 16'h0007);
    // every write combination, unit left off
    for (int k = 0; k < 16; k++)
    begin
      cfg({k[3:0], 1'b0});
      chk({13'h0, ls, inv, fr}, {13'h0, k[3] & k[2], k[1] & k[0], k[1]});
    end
    put(16'ha5c3);
    chk({15'h0, emp}, 16'h0000);
    cfg(5'h13);
    wait_rx;
    chk(word, 16'ha5c3);
    chk(rxd, 16'h3c5a);
    chk({15'h0, emp}, 16'h0001);
    cfg(5'h00);
    put(16'h0f0f);
    cfg(5'h15);
    wait_rx;
    chk(word, 16'h0f0f);
    chk(rxd, 16'h3c5a);
    repeat (12) @(posedge clk);
    cfg(5'h00);
    // master with late sampling, set in the same write
    put(16'hc3a5);
    cfg(5'h1b);
    wait_rx;
    chk(word, 16'hc3a5);
    chk(rxd, 16'h3c5a);
    cfg(5'h00);
    put(16'h1234);
    cfg(5'h01);
    @(posedge clk);
    tb_ss <= 1'b0;
    // far master clock, 200 ns period
    for (int b = 0; b < 32; b++)
    begin
      repeat (4) @(posedge clk);
      tb_sck <= ~tb_sck;
    end
    repeat (4) @(posedge clk);
    tb_ss <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(word, 16'h1234);
    chk({15'h0, emp}, 16'h0001);
    chk(rxd, 16'h3c5a);
    summarize;
  end
endmodule // tb_sfb_spi
`default_nettype wire
